// ---- pkg/counter_array_map.svh ----
`ifndef COUNTER_ARRAY_MAP_SVH
`define COUNTER_ARRAY_MAP_SVH

`define NUM_MODULES 5
`define WATCHDOG_MODULE 4

`define ADDR_EVENT_FLAGS 8'hD8
`define ADDR_ARRAY_MODE 8'hD9
`define ADDR_COUNTER_LOW 8'hE9
`define ADDR_COUNTER_HIGH 8'hF9
`define ADDR_MODULE_MODE_BASE 8'hDA
`define ADDR_MODULE_LOW_BASE 8'hEA
`define ADDR_MODULE_HIGH_BASE 8'hFA

`define RESET_ARRAY_MODE 8'h40
`define RESET_MODULE_MODE 8'h00
`define RESET_COUNTER 16'h0000
`define RESET_MODULE_VALUE 16'h0000

`define FLAG_OVF_BIT 7
`define ARRAY_MODE_WDT_BIT 6

`define TB_SYSCLK_DIV12 3'h0
`define TB_SYSCLK_DIV4 3'h1
`define TB_TIMER0_OVF 3'h2
`define TB_COUNT_FALL 3'h3
`define TB_SYSCLK 3'h4
`define TB_EXT_DIV8 3'h5

`define DIV12_LAST 4'hB
`define DIV4_LAST 2'h3
`define EXT_DIV8_LAST 3'h7

`endif

// ---- pkg/counter_array_pkg.sv ----
package counter_array_pkg;

   typedef struct packed {
      logic pwm16;
      logic comp_en;
      logic cap_pos;
      logic cap_neg;
      logic match_flag;
      logic toggle;
      logic pwm;
      logic irq_en;
   } module_mode_t;

   typedef struct packed {
      logic idle_suspend;
      logic watchdog_en;
      logic [1:0] spare;
      logic [2:0] timebase;
      logic ovf_irq_en;
   } array_mode_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

endpackage

// ---- src/line_sync.sv ----
`timescale 1ns/1ps
module line_sync (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_async,
   output logic o_level
);
   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;

   // level only moves once the two later stages agree
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
         o_level <= 1'b0;
      end else begin
         stage1_reg <= i_async;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         if (stage2_reg == stage3_reg) begin
            o_level <= stage3_reg;
         end
      end
   end
endmodule

// ---- src/timebase_divider.sv ----
`timescale 1ns/1ps
`include "counter_array_map.svh"
module timebase_divider (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ext_level,
   output logic o_div12_tick,
   output logic o_div4_tick,
   output logic o_ext8_tick
);
   logic [3:0] div12_reg;
   logic [1:0] div4_reg;
   logic [2:0] ext_reg;
   logic ext_prev_reg;
   wire ext_rise = i_ext_level & ~ext_prev_reg;

   // external clock is already resampled, so its /8 tick is a sysclk pulse
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         div12_reg <= 4'h0;
         div4_reg <= 2'h0;
         ext_reg <= 3'h0;
         ext_prev_reg <= 1'b0;
         o_div12_tick <= 1'b0;
         o_div4_tick <= 1'b0;
         o_ext8_tick <= 1'b0;
      end else begin
         div12_reg <= (div12_reg == `DIV12_LAST) ? 4'h0 : div12_reg + 4'h1;
         div4_reg <= div4_reg + 2'h1;
         ext_prev_reg <= i_ext_level;
         if (ext_rise) begin
            ext_reg <= ext_reg + 3'h1;
         end
         o_div12_tick <= (div12_reg == `DIV12_LAST);
         o_div4_tick <= (div4_reg == `DIV4_LAST);
         o_ext8_tick <= ext_rise & (ext_reg == `EXT_DIV8_LAST);
      end
   end
endmodule

// ---- src/programmable_counter_array.sv ----
// Functional notes
// - 16-bit counter in two bytes; low read snapshots high byte for next high read.
// - byte reads never disturb counting.
// - timebase select picks sysclk/12, /4, timer0 overflow, count falls, sysclk, ext/8.
// - external oscillator divided by eight is resynchronised to sysclk.
// - wrap from all ones to zero sets the overflow flag.
// - overflow raises a request only with overflow interrupt enable set.
// - overflow flag stays set through service; software clears it.
// - idle suspend clear keeps the array running while the core idles.
// - all six event flags set on trigger regardless of enables.
// - request is OR of flag AND enable, gated by global and array enables.
// - five independent 16-bit capture/compare modules, each with its own line.
// - mode bits 5 and 4 choose rising, falling or any-edge capture.
// - bit 3 software timer, bits 3+2 fast toggle, bits 2+1 frequency output.
// - bit 1 with bits 7 and 2 clear selects 8-bit PWM.
// - bits 7 and 1 with bit 2 clear select 16-bit PWM.
// - comparator off freezes toggling outputs and forces PWM output low.
// - in PWM modes the match-flag bit makes each match set the event flag.
// - mode bit 0 lets the module flag reach the request.
// - module 4 starts as watchdog; some registers are locked while it runs.
// - capture edge copies the counter into the module value and sets its flag.
// - module low byte write clears comparator enable, high byte write sets it.
// - fast toggle mode flips the line on each 16-bit match and flags it.
`timescale 1ns/1ps
`include "counter_array_map.svh"
module programmable_counter_array (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic [7:0] I_SFR_ADDR,
   input wire logic I_SFR_WR,
   input wire logic I_SFR_RD,
   input wire logic [7:0] I_SFR_WDATA,
   output logic [7:0] O_SFR_RDATA,
   input wire logic I_CPU_IDLE,
   input wire logic I_TIMER0_OVF,
   input wire logic I_COUNT_INPUT,
   input wire logic I_EXT_OSC,
   input wire logic I_GLOBAL_IRQ_EN,
   input wire logic I_ARRAY_IRQ_EN,
   output logic O_IRQ,
   input wire logic [4:0] I_MODULE_LINE,
   output logic [4:0] O_MODULE_LINE,
   output logic [4:0] O_MODULE_LINE_OE,
   output logic O_WATCHDOG_RESET
);
   localparam int N = `NUM_MODULES;

   counter_array_pkg::sfr_req_t req;
   counter_array_pkg::array_mode_t array_mode_reg;
   counter_array_pkg::array_mode_t array_mode_next;

   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic [7:0] snapshot_reg;
   logic step_reg;
   logic ovf_flag_reg;
   logic ovf_flag_next;
   logic [4:0] mod_flag_reg;
   logic [4:0] mod_flag_next;
   logic [4:0] mod_set;
   logic [4:0] mod_irq_en;
   logic [4:0] line_level;
   logic [4:0] line_prev_reg;
   logic [15:0] mod_value [N];
   logic [7:0] mod_rd [N];
   logic [7:0] rd_chain [N+1];
   logic count_level;
   logic count_prev_reg;
   logic ext_level;
   logic div12_tick;
   logic div4_tick;
   logic ext8_tick;

   assign req = '{wr: I_SFR_WR, rd: I_SFR_RD, addr: I_SFR_ADDR, wdata: I_SFR_WDATA};

   // input conditioning
   line_sync u_count_sync (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_async(I_COUNT_INPUT),
      .o_level(count_level)
   );

   line_sync u_ext_sync (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_async(I_EXT_OSC),
      .o_level(ext_level)
   );

   timebase_divider u_divider (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_ext_level(ext_level),
      .o_div12_tick(div12_tick),
      .o_div4_tick(div4_tick),
      .o_ext8_tick(ext8_tick)
   );

   // register decode
   wire wdt_on = array_mode_reg.watchdog_en;
   wire rd_count_lo = req.rd & (req.addr == `ADDR_COUNTER_LOW);
   wire rd_count_hi = req.rd & (req.addr == `ADDR_COUNTER_HIGH);
   // counter bytes are locked while the watchdog runs
   wire wr_count_lo = req.wr & (req.addr == `ADDR_COUNTER_LOW) & ~wdt_on;
   wire wr_count_hi = req.wr & (req.addr == `ADDR_COUNTER_HIGH) & ~wdt_on;
   wire wr_array_mode = req.wr & (req.addr == `ADDR_ARRAY_MODE);
   wire wr_flags = req.wr & (req.addr == `ADDR_EVENT_FLAGS);

   // timebase selection; codes 11x give no tick
   wire count_fall = count_prev_reg & ~count_level;
   wire [2:0] tb = array_mode_reg.timebase;
   wire tick_sel = (tb == `TB_SYSCLK_DIV12) ? div12_tick :
                   (tb == `TB_SYSCLK_DIV4) ? div4_tick :
                   (tb == `TB_TIMER0_OVF) ? I_TIMER0_OVF :
                   (tb == `TB_COUNT_FALL) ? count_fall :
                   (tb == `TB_SYSCLK) ? 1'b1 :
                   (tb == `TB_EXT_DIV8) ? ext8_tick :
                   1'b0;
   wire suspended = array_mode_reg.idle_suspend & I_CPU_IDLE;
   wire tick = tick_sel & ~suspended;
   wire wrap = tick & (count_reg == 16'hFFFF);

   // counter; reads leave it alone
   always_comb begin
      count_next = count_reg;
      if (wr_count_lo) begin
         count_next[7:0] = req.wdata;
      end else if (wr_count_hi) begin
         count_next[15:8] = req.wdata;
      end else if (tick) begin
         count_next = count_reg + 16'h0001;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         count_reg <= `RESET_COUNTER;
         step_reg <= 1'b0;
         count_prev_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         step_reg <= tick;
         count_prev_reg <= count_level;
      end
   end

   // snapshot makes low-then-high reads coherent across a carry
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         snapshot_reg <= 8'h00;
      end else if (rd_count_lo) begin
         snapshot_reg <= count_reg[15:8];
      end
   end

   // array mode; while the watchdog runs only its enable bit may change
   always_comb begin
      array_mode_next = array_mode_reg;
      if (wr_array_mode) begin
         if (wdt_on) begin
            array_mode_next.watchdog_en = req.wdata[`ARRAY_MODE_WDT_BIT];
         end else begin
            array_mode_next = counter_array_pkg::array_mode_t'(req.wdata);
            array_mode_next.spare = 2'h0;
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         array_mode_reg <= counter_array_pkg::array_mode_t'(`RESET_ARRAY_MODE);
      end else begin
         array_mode_reg <= array_mode_next;
      end
   end

   // flags: write 0 clears, write 1 keeps; a set in the same cycle wins
   wire [4:0] mod_clr = wr_flags ? ~req.wdata[4:0] : 5'h00;
   wire ovf_clr = wr_flags & ~req.wdata[`FLAG_OVF_BIT];
   assign ovf_flag_next = wrap | (ovf_flag_reg & ~ovf_clr);
   assign mod_flag_next = mod_set | (mod_flag_reg & ~mod_clr);

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         ovf_flag_reg <= 1'b0;
         mod_flag_reg <= 5'h00;
      end else begin
         ovf_flag_reg <= ovf_flag_next;
         mod_flag_reg <= mod_flag_next;
      end
   end

   // per-module logic
   assign rd_chain[0] = 8'h00;

   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_mod
         localparam logic is_wdt_slot = (i == `WATCHDOG_MODULE);
         counter_array_pkg::module_mode_t mode_reg;
         logic [15:0] value_reg;
         logic [15:0] value_next;
         logic comp_en_next;
         logic line_next;

         line_sync u_line_sync (
            .i_clk(I_CLK),
            .i_rst_n(I_RST_N),
            .i_async(I_MODULE_LINE[i]),
            .o_level(line_level[i])
         );

         wire [7:0] a_mode = `ADDR_MODULE_MODE_BASE + 8'(i);
         wire [7:0] a_low = `ADDR_MODULE_LOW_BASE + 8'(i);
         wire [7:0] a_high = `ADDR_MODULE_HIGH_BASE + 8'(i);
         wire locked = is_wdt_slot & wdt_on;
         wire wr_mode = req.wr & (req.addr == a_mode) & ~locked;
         wire wr_low = req.wr & (req.addr == a_low) & ~locked;
         wire wr_high = req.wr & (req.addr == a_high);

         // mode decode
         wire is_capture = mode_reg.cap_pos | mode_reg.cap_neg;
         wire is_hso = ~is_capture & mode_reg.toggle & ~mode_reg.pwm;
         wire is_freq = ~is_capture & mode_reg.toggle & mode_reg.pwm;
         wire is_pwm = ~is_capture & mode_reg.pwm & ~mode_reg.toggle;
         wire is_pwm8 = is_pwm & ~mode_reg.pwm16;
         wire is_pwm16 = is_pwm & mode_reg.pwm16;

         // matches are judged the cycle after the counter stepped
         wire cmp_on = mode_reg.comp_en;
         wire match16 = step_reg & cmp_on & (count_reg == value_reg);
         wire match8 = step_reg & cmp_on & (count_reg[7:0] == value_reg[7:0]);
         wire low_wrap = step_reg & (count_reg[7:0] == 8'h00);
         wire full_wrap = step_reg & (count_reg == 16'h0000);

         wire rise = line_level[i] & ~line_prev_reg[i];
         wire fall = ~line_level[i] & line_prev_reg[i];
         wire cap_edge = (mode_reg.cap_pos & rise) | (mode_reg.cap_neg & fall);
         wire cmp_hit = is_pwm8 ? match8 : match16;

         assign mod_set[i] = cap_edge |
                             (mode_reg.match_flag & ~is_capture & cmp_hit);
         assign mod_irq_en[i] = mode_reg.irq_en;
         assign mod_value[i] = value_reg;

         // value register
         always_comb begin
            value_next = value_reg;
            if (wr_low) begin
               value_next[7:0] = req.wdata;
            end else if (wr_high & locked) begin
               // watchdog update pushes the deadline ahead of the counter
               value_next = {count_reg[15:8] + req.wdata, count_reg[7:0]};
            end else if (wr_high) begin
               value_next[15:8] = req.wdata;
            end else if (is_capture & cap_edge) begin
               value_next = count_reg;
            end else if (is_freq & match8) begin
               value_next[7:0] = value_reg[7:0] + value_reg[15:8];
            end else if (is_pwm8 & low_wrap) begin
               value_next[7:0] = value_reg[15:8];
            end
         end

         always_comb begin
            comp_en_next = mode_reg.comp_en;
            if (wr_mode) begin
               comp_en_next = req.wdata[6];
            end else if (wr_low) begin
               comp_en_next = 1'b0;
            end else if (wr_high) begin
               comp_en_next = 1'b1;
            end
         end

         // output line; PWM set wins over the wrap reset for full duty
         always_comb begin
            line_next = O_MODULE_LINE[i];
            if ((is_hso & match16) | (is_freq & match8)) begin
               line_next = ~O_MODULE_LINE[i];
            end else if (is_pwm & ~cmp_on) begin
               line_next = 1'b0;
            end else if ((is_pwm8 & match8) | (is_pwm16 & match16)) begin
               line_next = 1'b1;
            end else if ((is_pwm8 & low_wrap) | (is_pwm16 & full_wrap)) begin
               line_next = 1'b0;
            end
         end

         always_ff @(posedge I_CLK) begin
            if (!I_RST_N) begin
               mode_reg <= counter_array_pkg::module_mode_t'(`RESET_MODULE_MODE);
               value_reg <= `RESET_MODULE_VALUE;
            end else begin
               if (wr_mode) begin
                  mode_reg <= counter_array_pkg::module_mode_t'(req.wdata);
               end
               mode_reg.comp_en <= comp_en_next;
               value_reg <= value_next;
            end
         end

         always_ff @(posedge I_CLK) begin
            if (!I_RST_N) begin
               O_MODULE_LINE[i] <= 1'b0;
               O_MODULE_LINE_OE[i] <= 1'b0;
               line_prev_reg[i] <= 1'b0;
            end else begin
               O_MODULE_LINE[i] <= line_next;
               O_MODULE_LINE_OE[i] <= ~is_capture & (mode_reg.toggle | mode_reg.pwm);
               line_prev_reg[i] <= line_level[i];
            end
         end

         assign mod_rd[i] = (req.addr == a_mode) ? mode_reg :
                            (req.addr == a_low) ? value_reg[7:0] :
                            (req.addr == a_high) ? value_reg[15:8] : 8'h00;
         assign rd_chain[i+1] = rd_chain[i] | mod_rd[i];
      end
   endgenerate

   // read data; unmapped addresses read zero
   wire [7:0] flags_rd = {ovf_flag_reg, 2'b00, mod_flag_reg};
   wire [7:0] rd_mux = (req.addr == `ADDR_COUNTER_LOW) ? count_reg[7:0] :
                       (req.addr == `ADDR_COUNTER_HIGH) ? snapshot_reg :
                       (req.addr == `ADDR_ARRAY_MODE) ? array_mode_reg :
                       (req.addr == `ADDR_EVENT_FLAGS) ? flags_rd :
                       rd_chain[N];

   // request combines each flag with its own enable
   wire any_event = (ovf_flag_reg & array_mode_reg.ovf_irq_en) |
                    (|(mod_flag_reg & mod_irq_en));
   wire irq_next = any_event & I_GLOBAL_IRQ_EN & I_ARRAY_IRQ_EN;
   wire wdt_fire = wdt_on & step_reg & (count_reg == mod_value[`WATCHDOG_MODULE]);

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         O_SFR_RDATA <= 8'h00;
         O_IRQ <= 1'b0;
         O_WATCHDOG_RESET <= 1'b0;
      end else begin
         if (req.rd) begin
            O_SFR_RDATA <= rd_mux;
         end
         O_IRQ <= irq_next;
         O_WATCHDOG_RESET <= wdt_fire;
      end
   end

   // high-byte read uses the snapshot, so rd_count_hi needs no action here
   wire unused_rd_hi = rd_count_hi;
endmodule

// ---- test/programmable_counter_array_chk.sv ----
`timescale 1ns/1ps
module programmable_counter_array_chk (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic [7:0] I_SFR_ADDR,
   input wire logic I_SFR_WR,
   input wire logic I_SFR_RD,
   input wire logic [7:0] I_SFR_WDATA,
   input wire logic [7:0] O_SFR_RDATA,
   input wire logic I_GLOBAL_IRQ_EN,
   input wire logic I_ARRAY_IRQ_EN,
   input wire logic O_IRQ,
   input wire logic [4:0] O_MODULE_LINE,
   input wire logic O_WATCHDOG_RESET
);
   default clocking dc @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);
   wire rd_mode2 = I_SFR_RD && I_SFR_ADDR == 8'hDC;
   wire rd_mode = I_SFR_RD && I_SFR_ADDR == 8'hD9;
   reset_quiet_a:
   assert property (disable iff (1'b0) !I_RST_N |=> !O_IRQ && O_MODULE_LINE == 5'h00
      && !O_WATCHDOG_RESET) else $error("outputs active after reset");
   irq_gate_a:
   assert property (O_IRQ |-> $past(I_GLOBAL_IRQ_EN) && $past(I_ARRAY_IRQ_EN))
      else $error("request without both core enables");
   irq_hold_a:
   assert property (O_IRQ && I_GLOBAL_IRQ_EN && I_ARRAY_IRQ_EN && !I_SFR_WR
      && !$past(I_SFR_WR) |=> O_IRQ) else $error("request dropped without a write");
   rdata_hold_a:
   assert property ($past(I_RST_N) && !$past(I_SFR_RD) |-> $stable(O_SFR_RDATA))
      else $error("read data moved without a read");
   low_clear_a:
   assert property (I_SFR_WR && I_SFR_ADDR == 8'hEC ##2 rd_mode2 |=> !O_SFR_RDATA[6])
      else $error("low byte write left comparator on");
   high_set_a:
   assert property (I_SFR_WR && I_SFR_ADDR == 8'hFC ##2 rd_mode2 |=> O_SFR_RDATA[6])
      else $error("high byte write left comparator off");
   wdog_bit_a:
   assert property (I_SFR_WR && I_SFR_ADDR == 8'hD9 ##2 rd_mode
      |=> O_SFR_RDATA[6] == $past(I_SFR_WDATA[6], 3)) else $error("watchdog bit not written");
   wdog_pulse_a:
   assert property (O_WATCHDOG_RESET |=> !O_WATCHDOG_RESET)
      else $error("watchdog reset longer than one cycle");
endmodule

bind programmable_counter_array programmable_counter_array_chk chk_i (.I_CLK(I_CLK),
   .I_RST_N(I_RST_N), .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_WR(I_SFR_WR), .I_SFR_RD(I_SFR_RD),
   .I_SFR_WDATA(I_SFR_WDATA), .O_SFR_RDATA(O_SFR_RDATA), .I_GLOBAL_IRQ_EN(I_GLOBAL_IRQ_EN),
   .I_ARRAY_IRQ_EN(I_ARRAY_IRQ_EN), .O_IRQ(O_IRQ), .O_MODULE_LINE(O_MODULE_LINE),
   .O_WATCHDOG_RESET(O_WATCHDOG_RESET));

// ---- test/pin_partner.sv ----
`timescale 1ns/1ps
module pin_partner (
   input wire logic i_clk,
   input wire logic i_run,
   input wire logic [4:0] i_line_level,
   output logic o_count,
   output logic o_ext,
   output logic o_timer0_ovf,
   output logic [4:0] o_line
);
   logic [2:0] phase_reg = 3'h0;
   always @(posedge i_clk) begin
      phase_reg <= i_run ? phase_reg + 3'h1 : 3'h0;
   end
   // one fall per 8 clocks, twice the shortest legal spacing
   assign o_count = !(i_run && phase_reg[2]);
   // oscillator stands still between bursts
   assign o_ext = i_run && phase_reg[2];
   assign o_timer0_ovf = i_run && phase_reg == 3'h7;
   // bench holds each level for many clocks
   assign o_line = i_line_level;
endmodule

// ---- test/programmable_counter_array_test.sv ----
`timescale 1ns/1ps
`define CHK(what, exp, got) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
   end
module programmable_counter_array_test;
   logic clk, rst_n, wr, rd, idle, gie, aie, run, wdog, irq, cnt, ext, t0;
   logic [7:0] addr, wdata, rdata;
   logic [4:0] level, pin, lout, loe, line_in;
   int err_count, check_count;
   // a pin the block drives reads back its own level
   assign line_in = (loe & lout) | (~loe & pin);
   programmable_counter_array programmable_counter_array_i (.I_CLK(clk), .I_RST_N(rst_n),
      .I_SFR_ADDR(addr), .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_WDATA(wdata),
      .O_SFR_RDATA(rdata), .I_CPU_IDLE(idle), .I_TIMER0_OVF(t0), .I_COUNT_INPUT(cnt),
      .I_EXT_OSC(ext), .I_GLOBAL_IRQ_EN(gie), .I_ARRAY_IRQ_EN(aie), .O_IRQ(irq),
      .I_MODULE_LINE(line_in), .O_MODULE_LINE(lout), .O_MODULE_LINE_OE(loe),
      .O_WATCHDOG_RESET(wdog));
   pin_partner pin_partner_i (.i_clk(clk), .i_run(run), .i_line_level(level),
      .o_count(cnt), .o_ext(ext), .o_timer0_ovf(t0), .o_line(pin));
   always #2.5 clk = ~clk;
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      q = rdata;
   endtask
   task automatic wreg(input logic [7:0] a, d);
      logic [7:0] q;
      acc(1'b1, a, d, q);
   endtask
   task automatic rchk(input logic [7:0] a, exp, input string what);
      logic [7:0] q;
      acc(1'b0, a, 8'h00, q);
      `CHK(what, exp, q)
   endtask
   task automatic run_sysclk;
      wreg(8'hD9, 8'h08);
      cyc(30);
      wreg(8'hD9, 8'h0C);
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check_reset;
      rchk(8'hD9, 8'h40, "array mode");
      rchk(8'hD8, 8'h00, "flags");
      rchk(8'h00, 8'h00, "unmapped");
      wreg(8'hDE, 8'h11);
      rchk(8'hDE, 8'h00, "locked mode");
   endtask
   task automatic check_watchdog;
      int n;
      wreg(8'hFE, 8'h01);
      for (n = 0; n < 3400 && wdog !== 1'b1; n++)
         cyc(1);
      `CHK("deadline", 1'b1, n >= 3040 && n <= 3100)
      if (n == 3400)
         end_of_test();
      wreg(8'hD9, 8'h0C);
      rchk(8'hD9, 8'h00, "watchdog off");
      wreg(8'hD9, 8'h0C);
      rchk(8'hD9, 8'h0C, "stopped mode");
   endtask
   task automatic check_counter;
      logic [7:0] q;
      wreg(8'hE9, 8'hF0);
      wreg(8'hF9, 8'hFF);
      rchk(8'hE9, 8'hF0, "held low");
      run_sysclk();
      rchk(8'hF9, 8'hFF, "snapshot");
      rchk(8'hD8, 8'h80, "overflow");
      acc(1'b0, 8'hE9, 8'h00, q);
      `CHK("wrapped low", 8'h10, q)
      rchk(8'hF9, 8'h00, "wrapped high");
      rchk(8'hE9, q, "still low");
   endtask
   task automatic check_irq;
      @(posedge clk);
      gie <= 1'b1;
      aie <= 1'b1;
      wreg(8'hD9, 8'h0D);
      cyc(3);
      `CHK("irq", 1'b1, irq)
      @(posedge clk);
      gie <= 1'b0;
      cyc(3);
      `CHK("irq", 1'b0, irq)
      @(posedge clk);
      gie <= 1'b1;
      wreg(8'hD9, 8'h0C);
      cyc(3);
      `CHK("irq", 1'b0, irq)
      wreg(8'hD9, 8'h0D);
      cyc(50);
      rchk(8'hD8, 8'h80, "kept flag");
      wreg(8'hD8, 8'h00);
      cyc(3);
      `CHK("irq", 1'b0, irq)
      wreg(8'hD9, 8'h0C);
   endtask
   task automatic check_sources;
      logic [2:0] code [3] = '{3'h2, 3'h3, 3'h5};
      logic [7:0] exp [3] = '{8'h10, 8'h10, 8'h02};
      logic [7:0] q;
      @(posedge clk);
      idle <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         wreg(8'hE9, 8'h00);
         wreg(8'hF9, 8'h00);
         wreg(8'hD9, {4'h0, code[i], 1'b0});
         @(posedge clk);
         run <= 1'b1;
         repeat (4) acc(1'b0, 8'hE9, 8'h00, q);
         repeat (120) @(posedge clk);
         run <= 1'b0;
         cyc(20);
         wreg(8'hD9, 8'h0C);
         rchk(8'hE9, exp[i], "source count");
      end
      @(posedge clk);
      idle <= 1'b0;
   endtask
   task automatic check_capture;
      wreg(8'hDA, 8'h20);
      wreg(8'hDB, 8'h11);
      wreg(8'hDC, 8'h30);
      wreg(8'hE9, 8'h34);
      wreg(8'hF9, 8'h12);
      @(posedge clk);
      level <= 5'h07;
      cyc(12);
      rchk(8'hD8, 8'h05, "rise flags");
      rchk(8'hFA, 8'h12, "capture high");
      `CHK("irq", 1'b0, irq)
      `CHK("capture oe", 5'h00, loe)
      wreg(8'hD8, 8'h00);
      wreg(8'hE9, 8'h78);
      wreg(8'hF9, 8'h56);
      @(posedge clk);
      level <= 5'h00;
      cyc(12);
      rchk(8'hD8, 8'h06, "fall flags");
      rchk(8'hEB, 8'h78, "capture low");
      `CHK("irq", 1'b1, irq)
      wreg(8'hD8, 8'h00);
   endtask
   task automatic check_compare;
      wreg(8'hE9, 8'h00);
      wreg(8'hF9, 8'h00);
      wreg(8'hEA, 8'h10);
      wreg(8'hFA, 8'h00);
      wreg(8'hDA, 8'h48);
      wreg(8'hDB, 8'h06);
      wreg(8'hDC, 8'h4C);
      wreg(8'hEC, 8'h10);
      rchk(8'hDC, 8'h0C, "low write");
      wreg(8'hFC, 8'h00);
      rchk(8'hDC, 8'h4C, "high write");
      wreg(8'hED, 8'h08);
      wreg(8'hDD, 8'h4A);
      wreg(8'hDE, 8'h82);
      cyc(1);
      `CHK("drive enables", 5'h1E, loe)
      run_sysclk();
      rchk(8'hD8, 8'h0D, "match flags");
      `CHK("lines", 5'h0C, lout)
      wreg(8'hEC, 8'h10);
      wreg(8'hE9, 8'h00);
      wreg(8'hEB, 8'h04);
      wreg(8'hFB, 8'h06);
      wreg(8'hEE, 8'h18);
      wreg(8'hFE, 8'h00);
      run_sysclk();
      `CHK("frozen line", 1'b1, lout[2])
      `CHK("tone lines", 5'h1E, lout)
      rchk(8'hEB, 8'h22, "tone step");
   endtask
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {wr, rd, idle, gie, aie, run} = 6'h00;
      addr = 8'h00;
      wdata = 8'h00;
      level = 5'h00;
      err_count = 0;
      check_count = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      check_reset();
      check_watchdog();
      check_counter();
      check_irq();
      check_sources();
      check_capture();
      check_compare();
      end_of_test();
   end
endmodule
